// ===== rtl/rsd_top.sv
// Power-up and power-down delay registers and per-rail sequencing of four outputs
//
// Notes on behaviour
// [R1] Offset 0x09 bits 4:0 hold fourth rail power-up wait; upper bits zero, reset zero.
// [R2] Offset 0x0A bits 4:0 hold first rail power-down wait, 0 to 31 steps.
// [R3] Offset 0x0B bits 4:0 hold second rail power-down wait, reset zero.
// [R4] Offset 0x0C bits 4:0 hold third rail power-down wait, reset zero.
// [R5] Offset 0x0D bits 4:0 hold fourth rail power-down wait; zero turns off at once.
// [R6] One select bit picks a 1 ms or 2 ms step for every wait.
// [R7] A rail is on when its register enable or its input enable is set.
// [R8] Global enable rise starts power-up waits; its fall starts power-down waits.
`timescale 1ns/100ps
`default_nettype none
`include "rsd_defs.svh"

module rsd_top
  import rsd_pkg::*;
#(
  parameter int unsigned STEP_CYC = `RSD_STEP_SHORT_CYC,
  parameter int unsigned CW = 22
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire rsd_reg_req_t req_i,
  input wire logic wait_unit_select_i,
  input wire logic en_pin_i,
  input wire logic global_turn_on_i,
  input wire rsd_rail_en_t rail_en_i,
  input wire rsd_ext_wait_t ext_wait_i,
  output logic [7:0] reg_rdata_o,
  output logic [3:0] rail_on_o
);

  function automatic logic hit(input rsd_reg_req_t r, input logic [7:0] ofs);
    hit = r.wr && (r.addr == ofs);
  endfunction

  logic [4:0] fourth_rail_powerup_wait_r;
  logic [4:0] pwrdn_wait_r [4];
  logic glob_r;
  logic glob;
  logic rise;
  logic fall;
  logic [CW-1:0] pre_cnt_r;
  logic [CW-1:0] step_cyc;
  logic tick;
  logic [4:0] pwrup_code [4];
  logic [3:0] seq_on;
  rsd_phase_t phase_r [4];

  // Register writes
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      fourth_rail_powerup_wait_r <= `RSD_WAIT_RESET;
    end else if (hit(req_i, `RSD_OFS_PWRUP4)) begin
      fourth_rail_powerup_wait_r <= req_i.wdata[`RSD_WAIT_MSB:`RSD_WAIT_LSB]; // [R1]
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pwrdn_wait_r[0] <= `RSD_WAIT_RESET;
      pwrdn_wait_r[1] <= `RSD_WAIT_RESET;
      pwrdn_wait_r[2] <= `RSD_WAIT_RESET;
      pwrdn_wait_r[3] <= `RSD_WAIT_RESET;
    end else begin
      if (hit(req_i, `RSD_OFS_PWRDN1)) begin
        pwrdn_wait_r[0] <= req_i.wdata[`RSD_WAIT_MSB:`RSD_WAIT_LSB]; // [R2]
      end
      if (hit(req_i, `RSD_OFS_PWRDN2)) begin
        pwrdn_wait_r[1] <= req_i.wdata[`RSD_WAIT_MSB:`RSD_WAIT_LSB]; // [R3]
      end
      if (hit(req_i, `RSD_OFS_PWRDN3)) begin
        pwrdn_wait_r[2] <= req_i.wdata[`RSD_WAIT_MSB:`RSD_WAIT_LSB]; // [R4]
      end
      if (hit(req_i, `RSD_OFS_PWRDN4)) begin
        pwrdn_wait_r[3] <= req_i.wdata[`RSD_WAIT_MSB:`RSD_WAIT_LSB]; // [R5]
      end
    end
  end

  // Read data; reserved bits and unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= `RSD_RDATA_RESET;
    end else if (req_i.rd) begin
      unique case (req_i.addr)
        `RSD_OFS_PWRUP4: reg_rdata_o <= {3'h0, fourth_rail_powerup_wait_r};
        `RSD_OFS_PWRDN1: reg_rdata_o <= {3'h0, pwrdn_wait_r[0]};
        `RSD_OFS_PWRDN2: reg_rdata_o <= {3'h0, pwrdn_wait_r[1]};
        `RSD_OFS_PWRDN3: reg_rdata_o <= {3'h0, pwrdn_wait_r[2]};
        `RSD_OFS_PWRDN4: reg_rdata_o <= {3'h0, pwrdn_wait_r[3]};
        default: reg_rdata_o <= `RSD_RDATA_RESET;
      endcase
    end
  end

  // Global enable edges
  assign glob = en_pin_i | global_turn_on_i;
  assign rise = glob & ~glob_r; // [R8]
  assign fall = ~glob & glob_r; // [R8]

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      glob_r <= 1'b0;
    end else begin
      glob_r <= glob;
    end
  end

  // Shared step prescaler, restarted on each edge so the first step is whole
  assign step_cyc = wait_unit_select_i ? CW'(STEP_CYC * `RSD_STEP_LONG_MS)
                                       : CW'(STEP_CYC * `RSD_STEP_SHORT_MS); // [R6]
  assign tick = (pre_cnt_r >= step_cyc - CW'(1));

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pre_cnt_r <= '0;
    end else if (rise || fall || tick) begin
      pre_cnt_r <= '0; // [R6]
    end else begin
      pre_cnt_r <= pre_cnt_r + CW'(1);
    end
  end

  // First rail has no power-up wait of its own
  assign pwrup_code[0] = 5'h00;
  assign pwrup_code[1] = ext_wait_i.second_rail_powerup_wait;
  assign pwrup_code[2] = ext_wait_i.third_rail_powerup_wait;
  assign pwrup_code[3] = fourth_rail_powerup_wait_r;

  generate
    for (genvar g = 0; g < 4; g++) begin : g_rail
      logic [4:0] steps_r;

      always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
          phase_r[g] <= RSD_OFF;
          steps_r <= 5'h00;
        end else if (rise) begin
          steps_r <= pwrup_code[g];
          phase_r[g] <= (pwrup_code[g] == 5'h00) ? RSD_ON : RSD_WAIT_ON; // [R8]
        end else if (fall) begin
          steps_r <= pwrdn_wait_r[g];
          phase_r[g] <= (pwrdn_wait_r[g] == 5'h00) ? RSD_OFF : RSD_WAIT_OFF; // [R8]
        end else if (tick) begin
          unique case (phase_r[g])
            RSD_WAIT_ON: begin
              steps_r <= steps_r - 5'h01;
              if (steps_r == 5'h01) begin
                phase_r[g] <= RSD_ON;
              end
            end
            RSD_WAIT_OFF: begin
              steps_r <= steps_r - 5'h01;
              if (steps_r == 5'h01) begin
                phase_r[g] <= RSD_OFF;
              end
            end
            RSD_OFF, RSD_ON: begin
              steps_r <= steps_r;
            end
          endcase
        end
      end

      // Rail keeps running through its power-down wait
      assign seq_on[g] = (phase_r[g] == RSD_ON) || (phase_r[g] == RSD_WAIT_OFF);
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rail_on_o <= 4'h0;
    end else begin
      rail_on_o <= seq_on | rail_en_i.rail_reg_on | rail_en_i.rail_gpi_on; // [R7]
    end
  end

  // Checks
  sequence s_rise_direct4;
    rise && (fourth_rail_powerup_wait_r == 5'h00);
  endsequence

  sequence s_wr_rd_pwrdn1;
    hit(req_i, `RSD_OFS_PWRDN1) ##1 req_i.rd && req_i.addr == `RSD_OFS_PWRDN1;
  endsequence

  a_wr_pwrup4: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R1]
    hit(req_i, `RSD_OFS_PWRUP4) |=> fourth_rail_powerup_wait_r == $past(req_i.wdata[4:0]))
    else $error("fourth rail power-up wait not stored");
  a_wr_pwrdn1: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R2]
    s_wr_rd_pwrdn1 |=> reg_rdata_o == {3'h0, $past(req_i.wdata[4:0], 2)})
    else $error("first rail power-down wait readback wrong");
  a_wr_pwrdn2: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R3]
    hit(req_i, `RSD_OFS_PWRDN2) |=> pwrdn_wait_r[1] == $past(req_i.wdata[4:0]))
    else $error("second rail power-down wait not stored");
  a_wr_pwrdn3: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R4]
    hit(req_i, `RSD_OFS_PWRDN3) |=> pwrdn_wait_r[2] == $past(req_i.wdata[4:0]))
    else $error("third rail power-down wait not stored");
  a_off_direct4: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R5]
    fall && pwrdn_wait_r[3] == 5'h00 |=> phase_r[3] == RSD_OFF)
    else $error("fourth rail not off at once for zero wait");
  a_step_length: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R6]
    // A select change may end the running step early, so only a steady select is timed
    tick && $stable(wait_unit_select_i)
    |-> pre_cnt_r == (wait_unit_select_i ? CW'(2 * STEP_CYC) : CW'(STEP_CYC)) - CW'(1))
    else $error("step length wrong");
  a_rail_or: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R7]
    (rail_en_i.rail_reg_on[0] || rail_en_i.rail_gpi_on[0]) |=> rail_on_o[0])
    else $error("first rail not on with its enable");
  a_wait_off1: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R2]
    fall && pwrdn_wait_r[0] != 5'h00 |=> phase_r[0] == RSD_WAIT_OFF)
    else $error("first rail did not start its power-down wait");
  a_hold_on1: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R2]
    phase_r[0] == RSD_WAIT_OFF |=> rail_on_o[0])
    else $error("first rail dropped during its power-down wait");
  a_rise_start: assert property (@(posedge clk_i) disable iff (!rstn_i) // [R8]
    s_rise_direct4 |=> phase_r[3] == RSD_ON ##1 rail_on_o[3])
    else $error("fourth rail not on after enable rise");

endmodule

`default_nettype wire

// ===== rtl/rsd_defs.svh
// Register offsets, field positions, reset values and timing figures of the rail sequencer
`ifndef RSD_DEFS_SVH
`define RSD_DEFS_SVH

`define RSD_OFS_PWRUP4 8'h09
`define RSD_OFS_PWRDN1 8'h0A
`define RSD_OFS_PWRDN2 8'h0B
`define RSD_OFS_PWRDN3 8'h0C
`define RSD_OFS_PWRDN4 8'h0D

`define RSD_WAIT_MSB 4
`define RSD_WAIT_LSB 0
`define RSD_WAIT_RESET 5'h00
`define RSD_RDATA_RESET 8'h00

`define RSD_CLK_HZ 50000000
`define RSD_STEP_SHORT_MS 1
`define RSD_STEP_LONG_MS 2
`define RSD_STEP_SHORT_CYC ((`RSD_CLK_HZ / 1000) * `RSD_STEP_SHORT_MS)

`endif

// ===== rtl/rsd_pkg.sv
// Types shared by the rail sequencer and its users
`default_nettype none

package rsd_pkg;

  typedef enum logic [1:0] {
    RSD_OFF = 2'b00,
    RSD_WAIT_ON = 2'b01,
    RSD_ON = 2'b10,
    RSD_WAIT_OFF = 2'b11
  } rsd_phase_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } rsd_reg_req_t;

  typedef struct packed {
    logic [3:0] rail_reg_on;
    logic [3:0] rail_gpi_on;
  } rsd_rail_en_t;

  typedef struct packed {
    logic [4:0] second_rail_powerup_wait;
    logic [4:0] third_rail_powerup_wait;
  } rsd_ext_wait_t;

endpackage

`default_nettype wire

// ===== tb/rsd_top_tb.sv
// Self-checking bench for the rail sequencer registers and timing
`timescale 1ns/100ps
`default_nettype none

module rsd_top_tb
  import rsd_pkg::*;
;
  localparam int STEP = 4;
  logic clk_i;
  logic rstn_i = 1'b0;
  logic sel = 1'b0;
  logic en_pin = 1'b0;
  logic glb = 1'b0;
  rsd_reg_req_t req = '0;
  rsd_rail_en_t ren = '0;
  rsd_ext_wait_t ext = '0;
  logic [7:0] rdata;
  logic [3:0] rail_on;
  int n_fail = 0;
  int num_checks = 0;

  rsd_top #(.STEP_CYC(STEP)) rsd_top_i (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .req_i(req),
    .wait_unit_select_i(sel),
    .en_pin_i(en_pin),
    .global_turn_on_i(glb),
    .rail_en_i(ren),
    .ext_wait_i(ext),
    .reg_rdata_o(rdata),
    .rail_on_o(rail_on)
  );

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask

  task automatic check(string nm, int e, int g, bit ok);
    num_checks++;
    if (!ok) begin
      n_fail++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // One cycle for the edge detect and one for the output flop
  function automatic int wait_cycles(logic [4:0] code, logic unit);
    return int'(code) * STEP * (int'(unit) + 1) + 2;
  endfunction

  // Write, then read in the very next cycle; the read must see the new value
  task automatic wr_rd(string nm, logic [7:0] a, logic [7:0] d);
    logic [7:0] e;
    e = {3'h0, d[4:0]};
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    tick();
    req.wr = 1'b0;
    req.rd = 1'b1;
    tick();
    req.rd = 1'b0;
    tick();
    check(nm, e, rdata, rdata === e);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    tick();
    req.wr = 1'b0;
    tick();
  endtask

  task automatic rd_chk(string nm, logic [7:0] a, logic [7:0] e);
    req.addr = a;
    req.rd = 1'b1;
    tick();
    req.rd = 1'b0;
    tick();
    check(nm, e, rdata, rdata === e);
  endtask

  // Records the first cycle each rail reaches v; fixed span keeps rails independent
  task automatic run_seq(logic v, int e[4]);
    int t[4];
    t = '{-1, -1, -1, -1};
    for (int c = 1; c <= 300; c++) begin
      tick();
      foreach (t[i]) if (t[i] < 0 && rail_on[i] === v) t[i] = c;
    end
    foreach (t[i]) check("rail_time", e[i], t[i], t[i] == e[i]);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end

  initial begin
    void'($urandom(22));
    repeat (10) tick();
    rstn_i = 1'b1;
    for (int a = 9; a <= 14; a++) rd_chk("reset_val", 8'(a), 8'h00);
    $display("test reset done");
    for (int it = 0; it < 6; it++) begin
      logic [4:0] cu[4];
      logic [4:0] cd[4];
      int e[4];
      sel = (it < 2) ? it[0] : 1'($urandom);
      foreach (cu[j]) begin
        // First pass longest waits, second pass zero waits
        cu[j] = (it == 0) ? 5'h1F : (it == 1) ? 5'h00 : 5'($urandom);
        cd[j] = (it == 0) ? 5'h1F : (it == 1) ? 5'h00 : 5'($urandom);
      end
      cu[0] = 5'h00;
      ext.second_rail_powerup_wait = cu[1];
      ext.third_rail_powerup_wait = cu[2];
      wr(8'h09, {3'($urandom), cu[3]});
      rd_chk("pwrup4", 8'h09, {3'b000, cu[3]});
      for (int j = 0; j < 4; j++) begin
        wr_rd("pwrdn", 8'h0A + 8'(j), {3'($urandom), cd[j]});
      end
      wr(8'h0E, 8'hFF);
      rd_chk("unmapped", 8'h0E, 8'h00);
      if (it % 2 == 1) en_pin = 1'b1;
      else glb = 1'b1;
      foreach (e[j]) e[j] = wait_cycles(cu[j], sel);
      run_seq(1'b1, e);
      en_pin = 1'b0;
      glb = 1'b0;
      foreach (e[j]) e[j] = wait_cycles(cd[j], sel);
      run_seq(1'b0, e);
      ren = 8'($urandom);
      tick();
      tick();
      check("rail_or", ren.rail_reg_on | ren.rail_gpi_on, rail_on,
            rail_on === (ren.rail_reg_on | ren.rail_gpi_on));
      ren = '0;
      tick();
      tick();
      $display("test %0d done", it);
    end
    // Reset in mid-run; enable still high at release counts as a fresh rise
    wr(8'h0D, 8'h1F);
    glb = 1'b1;
    repeat (5) tick();
    rstn_i = 1'b0;
    tick();
    tick();
    check("reset_rail", 0, rail_on, rail_on === 4'h0);
    rstn_i = 1'b1;
    rd_chk("reset_mid", 8'h0D, 8'h00);
    check("reset_rise0", 1, rail_on[0], rail_on[0] === 1'b1);
    check("reset_rise3", 1, rail_on[3], rail_on[3] === 1'b1);
    $display("test reset_mid done");
    finish_test();
  end
endmodule

`default_nettype wire
